//--- rtl/sdc_defs.svh
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
// Organization codes held in the configuration register
`define SDC_ORG_ICACHE    2'h0
`define SDC_ORG_DCACHE    2'h1
`define SDC_ORG_SPLIT     2'h2
`define SDC_ORG_RESET     2'h0
// Address fields
`define SDC_TAG_MSB       31
`define SDC_TAG_LSB       10
`define SDC_LINE_MSB      10
`define SDC_LINE_LSB      4
`define SDC_SPLIT_MSB     9
`define SDC_WORD_MSB      3
`define SDC_WORD_LSB      2
// Geometry
`define SDC_LINES         128
`define SDC_WORDS         512
`define SDC_FILL_BEATS    3'h4
`endif

//--- rtl/sdc_pkg.sv
`default_nettype none
package sdc_pkg;
    typedef struct packed {
        logic        req;
        logic        we;
        logic        ifetch;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sdc_core_req_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sdc_sys_req_t;

    typedef enum logic [1:0] {
        SDC_IDLE  = 2'b00,
        SDC_FILL  = 2'b01,
        SDC_WRITE = 2'b10,
        SDC_DONE  = 2'b11
    } sdc_state_t;
endpackage : sdc_pkg
`default_nettype wire

//--- rtl/sdc_fill_buffer.sv
`include "sdc_defs.svh"
`default_nettype none
// One-line fill buffer: four words collected in order
module sdc_fill_buffer (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         clear_i,
    input  wire logic         beat_i,
    input  wire logic [31:0]  data_i,
    output logic      [127:0] line_o,
    output logic              full_o
);
    logic [2:0] count_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_r <= 3'h0;
        end else if (clear_i) begin
            count_r <= 3'h0;
        end else if (beat_i && count_r != `SDC_FILL_BEATS) begin
            count_r <= count_r + 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_o <= 128'h0;
        end else if (beat_i && !clear_i && count_r != `SDC_FILL_BEATS) begin
            line_o[count_r[1:0]*32 +: 32] <= data_i; // [R9]
        end
    end

    assign full_o = (count_r == `SDC_FILL_BEATS);
endmodule : sdc_fill_buffer
`default_nettype wire

//--- rtl/sdc_cache.sv
`include "sdc_defs.svh"
`default_nettype none
// Function
// R1: Organizations: 2 KB instruction, 2 KB data, or 1 KB plus 1 KB split.
// R2: Organization set by control register, writable only at supervisor level.
// R3: Direct-mapped, single-cycle, 128 lines of 16 bytes.
// R4: 128-entry tag array and 512 x 32 data array.
// R5: Unified modes index tag by addr[10:4], data by addr[10:2].
// R6: Split mode forces top index bit: 0 instruction, 1 operand.
// R7: Hit drives data word to core and completes in one cycle.
// R8: Miss starts a 16-byte line fetch on the system bus.
// R9: One-line fill buffer holds incoming fill data.
// R10: Data caching uses write-through; every operand write goes external.
// R11: Valid bits cleared at reset; no hit until line filled.
// R12: Line written to arrays only after all four words collected.
module sdc_cache (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    // Configuration register write
    input  wire logic                  cfg_we_i,
    input  wire logic                  cfg_super_i,
    input  wire logic [1:0]            cfg_org_i,
    output logic      [1:0]            cache_organization_control_reg_o,
    // Core local bus
    input  wire sdc_pkg::sdc_core_req_t core_i,
    output logic                       core_ack_o,
    output logic                       core_hit_o,
    output logic                       core_miss_o,
    output logic      [31:0]           core_rdata_o,
    // System bus
    output sdc_pkg::sdc_sys_req_t      sys_o,
    input  wire logic                  sys_ack_i,
    input  wire logic [31:0]           sys_rdata_i
);
    logic [1:0]              org_r;
    logic [`SDC_LINES-1:0]   valid_r;
    // Tag keeps bit 10 so split-mode halves cannot alias
    logic [21:0]             tag_mem [`SDC_LINES];
    logic [31:0]             data_mem [`SDC_WORDS];
    sdc_pkg::sdc_state_t     state_r;
    sdc_pkg::sdc_core_req_t  hold_r;
    logic [1:0]              beat_r;

    // Configuration register, supervisor only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            org_r <= `SDC_ORG_RESET;
        end else if (cfg_we_i && cfg_super_i && cfg_org_i != 2'h3) begin
            org_r <= cfg_org_i; // [R1] [R2]
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cache_organization_control_reg_o <= `SDC_ORG_RESET;
        end else begin
            cache_organization_control_reg_o <= org_r;
        end
    end

    // Index formation; request is taken from the held copy during a miss
    sdc_pkg::sdc_core_req_t cur;
    logic       cacheable;
    logic [6:0] line_idx;
    logic [8:0] word_idx;
    logic       hit;
    logic       take;

    // Request still high in the cycle after an ack is not a new access
    assign take = (state_r == sdc_pkg::SDC_IDLE) && core_i.req && !core_ack_o;

    always_comb begin
        cur = (state_r == sdc_pkg::SDC_IDLE) ? core_i : hold_r;
        unique case (org_r)
            `SDC_ORG_ICACHE: cacheable = cur.ifetch;
            `SDC_ORG_DCACHE: cacheable = !cur.ifetch;
            default:         cacheable = 1'b1;
        endcase
        if (org_r == `SDC_ORG_SPLIT) begin
            line_idx = {!cur.ifetch, cur.addr[`SDC_SPLIT_MSB:`SDC_LINE_LSB]}; // [R6]
        end else begin
            line_idx = cur.addr[`SDC_LINE_MSB:`SDC_LINE_LSB]; // [R5]
        end
        word_idx = {line_idx, cur.addr[`SDC_WORD_MSB:`SDC_WORD_LSB]}; // [R5] [R6]
        hit = valid_r[line_idx] && cacheable && // [R11]
              tag_mem[line_idx] == cur.addr[`SDC_TAG_MSB:`SDC_TAG_LSB]; // [R3] [R4]
    end

    // Fill buffer
    logic         fb_clear;
    logic         fb_beat;
    logic [127:0] fb_line;
    logic         fb_full;

    assign fb_clear = (state_r == sdc_pkg::SDC_IDLE);
    assign fb_beat  = (state_r == sdc_pkg::SDC_FILL) && sys_ack_i;

    sdc_fill_buffer u_fill (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .clear_i  (fb_clear),
        .beat_i   (fb_beat),
        .data_i   (sys_rdata_i),
        .line_o   (fb_line),
        .full_o   (fb_full)
    );

    // Control sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= sdc_pkg::SDC_IDLE;
            hold_r  <= '0;
            beat_r  <= 2'h0;
        end else begin
            unique case (state_r)
                sdc_pkg::SDC_IDLE: begin
                    beat_r <= 2'h0;
                    if (take) begin
                        hold_r <= core_i;
                        if (core_i.we) begin
                            state_r <= sdc_pkg::SDC_WRITE; // [R10]
                        end else if (!hit) begin
                            state_r <= sdc_pkg::SDC_FILL; // [R8]
                        end
                    end
                end
                sdc_pkg::SDC_FILL: begin
                    if (sys_ack_i) begin
                        beat_r <= beat_r + 2'h1;
                        if (beat_r == 2'h3) begin
                            state_r <= sdc_pkg::SDC_DONE;
                        end
                    end
                end
                sdc_pkg::SDC_WRITE: begin
                    if (sys_ack_i) begin
                        state_r <= sdc_pkg::SDC_IDLE;
                    end
                end
                sdc_pkg::SDC_DONE: begin
                    state_r <= sdc_pkg::SDC_IDLE;
                end
            endcase
        end
    end

    // Array update: whole line once buffer is full; write hits updated in place
    logic write_hit;
    assign write_hit = take && core_i.we && hit;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid_r <= '0; // [R11]
        end else if (state_r == sdc_pkg::SDC_DONE && fb_full && cacheable) begin
            valid_r[line_idx] <= 1'b1; // [R12]
        end
    end

    always_ff @(posedge clk_i) begin
        if (state_r == sdc_pkg::SDC_DONE && fb_full && cacheable) begin
            tag_mem[line_idx] <= hold_r.addr[`SDC_TAG_MSB:`SDC_TAG_LSB]; // [R12]
            for (int w = 0; w < 4; w++) begin
                data_mem[{line_idx, w[1:0]}] <= fb_line[w*32 +: 32]; // [R12]
            end
        end else if (write_hit) begin
            data_mem[word_idx] <= core_i.wdata; // [R10]
        end
    end

    // Core answers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_ack_o   <= 1'b0;
            core_hit_o   <= 1'b0;
            core_miss_o  <= 1'b0;
            core_rdata_o <= 32'h0;
        end else begin
            core_ack_o  <= 1'b0;
            core_hit_o  <= 1'b0;
            core_miss_o <= 1'b0;
            if (take && !core_i.we) begin
                if (hit) begin
                    core_ack_o   <= 1'b1; // [R7]
                    core_hit_o   <= 1'b1;
                    core_rdata_o <= data_mem[word_idx]; // [R7]
                end else begin
                    core_miss_o <= 1'b1; // [R8]
                end
            end else if (state_r == sdc_pkg::SDC_DONE) begin
                core_ack_o   <= 1'b1;
                core_rdata_o <= fb_line[hold_r.addr[`SDC_WORD_MSB:`SDC_WORD_LSB]*32 +: 32];
            end else if (state_r == sdc_pkg::SDC_WRITE && sys_ack_i) begin
                core_ack_o <= 1'b1;
            end
        end
    end

    // System bus: line-aligned burst on miss, single word on write
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sys_o <= '0;
        end else begin
            sys_o.req <= 1'b0;
            if (take) begin
                if (core_i.we) begin
                    sys_o.req   <= 1'b1; // [R10]
                    sys_o.we    <= 1'b1;
                    sys_o.addr  <= core_i.addr;
                    sys_o.wdata <= core_i.wdata;
                end else if (!hit) begin
                    sys_o.req  <= 1'b1; // [R8]
                    sys_o.we   <= 1'b0;
                    sys_o.addr <= {core_i.addr[31:4], 4'h0};
                end
            end else if (state_r == sdc_pkg::SDC_FILL && !(sys_ack_i && beat_r == 2'h3)) begin
                sys_o.req  <= 1'b1;
                sys_o.addr <= {hold_r.addr[31:4], beat_r + (sys_ack_i ? 2'h1 : 2'h0), 2'h0};
            end else if (state_r == sdc_pkg::SDC_WRITE && !sys_ack_i) begin
                sys_o.req <= 1'b1;
            end
        end
    end
endmodule : sdc_cache
`default_nettype wire

//--- bench/sdc_sys_model.sv
`default_nettype none
// System bus memory: word data derived from its address, ack wait_i + 1 cycles after the request is seen
module sdc_sys_model (
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire sdc_pkg::sdc_sys_req_t sys_i,
    input  wire logic [1:0]           wait_i,
    output logic                      ack_o,
    output logic      [31:0]          rdata_o,
    output logic      [7:0]           wr_cnt_o,
    output logic      [31:0]          wr_addr_o,
    output logic      [31:0]          wr_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    // Off-beat data is inverted so stale words never match
    assign rdata_o = ack_o ? (sys_i.addr ^ 32'h5a5a_0000) : ~(sys_i.addr ^ 32'h5a5a_0000);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_o <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            ack_o <= sys_i.req && !ack_o && cnt_r >= wait_i;
            cnt_r <= (sys_i.req && !ack_o && cnt_r < wait_i) ? cnt_r + 2'h1 : 2'h0;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_cnt_o  <= 8'h0;
            wr_addr_o <= 32'h0;
            wr_data_o <= 32'h0;
        end else if (ack_o && sys_i.we) begin
            wr_cnt_o  <= wr_cnt_o + 8'h1;
            wr_addr_o <= sys_i.addr;
            wr_data_o <= sys_i.wdata;
        end
    end
endmodule : sdc_sys_model
`default_nettype wire

//--- bench/sdc_cache_assertions.sv
`default_nettype none
module sdc_cache_checker (
    input wire logic                  clk_i,
    input wire logic                  resetn_i,
    input wire logic                  cfg_we_i,
    input wire logic                  cfg_super_i,
    input wire logic [1:0]            cfg_org_i,
    input wire logic [1:0]            cache_organization_control_reg_o,
    input wire sdc_pkg::sdc_core_req_t core_i,
    input wire logic                  core_ack_o,
    input wire logic                  core_hit_o,
    input wire logic                  core_miss_o,
    input wire logic [31:0]           core_rdata_o,
    input wire sdc_pkg::sdc_sys_req_t  sys_o,
    input wire logic                  sys_ack_i,
    input wire logic [31:0]           sys_rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    hit_acks_a: assert property (core_hit_o |-> core_ack_o) else $error("hit without ack");
    hit_miss_a: assert property (!(core_hit_o && core_miss_o)) else $error("hit and miss");
    miss_fetch_a: assert property (core_miss_o |=> sys_o.req && !sys_o.we)
        else $error("miss without fetch");
    fill_line_a: assert property (sys_o.req && !sys_o.we |-> sys_o.addr[31:4] == core_i.addr[31:4])
        else $error("fill outside line");
    fill_commit_a: assert property (sys_ack_i && !sys_o.we && sys_o.addr[3:2] == 2'h3
        |-> ##[1:2] core_ack_o) else $error("fill not completed");
    write_out_a: assert property (sys_o.req && sys_o.we |-> sys_o.addr == core_i.addr
        && sys_o.wdata == core_i.wdata) else $error("write cycle mismatch");
    write_ack_a: assert property (sys_o.req && sys_o.we && sys_ack_i |=> core_ack_o)
        else $error("write ack late");
    beat_hold_a: assert property (sys_o.req && !sys_ack_i |=> sys_o.req && $stable(sys_o.addr))
        else $error("beat dropped");
    cfg_guard_a: assert property (cfg_we_i && !cfg_super_i
        |=> ##1 $stable(cache_organization_control_reg_o)) else $error("user write took effect");
    cfg_take_a: assert property (cfg_we_i && cfg_super_i && cfg_org_i != 2'h3
        |=> ##1 cache_organization_control_reg_o == $past(cfg_org_i, 2))
        else $error("org not taken");
endmodule : sdc_cache_checker
bind sdc_cache sdc_cache_checker i_sdc_cache_checker (.clk_i, .resetn_i, .cfg_we_i, .cfg_super_i,
    .cfg_org_i, .cache_organization_control_reg_o, .core_i, .core_ack_o, .core_hit_o,
    .core_miss_o, .core_rdata_o, .sys_o, .sys_ack_i, .sys_rdata_i);
`default_nettype wire

//--- bench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, resetn_i = 1'b0, cfg_we_i = 1'b0, cfg_super_i = 1'b0;
    logic [1:0]  cfg_org_i = 2'h0, org, wt = 2'h0;
    logic        ack, hit, miss, sack, h, m;
    logic [31:0] rdata, srd, d, wa, wd;
    logic [7:0]  wc;
    int          failures = 0, total_checks = 0;
    sdc_pkg::sdc_core_req_t core_i = '0;
    sdc_pkg::sdc_sys_req_t  sys;
    sdc_cache i_sdc_cache (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_we_i(cfg_we_i),
        .cfg_super_i(cfg_super_i), .cfg_org_i(cfg_org_i), .cache_organization_control_reg_o(org),
        .core_i(core_i), .core_ack_o(ack), .core_hit_o(hit), .core_miss_o(miss),
        .core_rdata_o(rdata), .sys_o(sys), .sys_ack_i(sack), .sys_rdata_i(srd));
    sdc_sys_model i_sdc_sys_model (.clk_i(clk_i), .resetn_i(resetn_i), .sys_i(sys), .wait_i(wt),
        .ack_o(sack), .rdata_o(srd), .wr_cnt_o(wc), .wr_addr_o(wa), .wr_data_o(wd));
    initial forever #20 clk_i = ~clk_i;
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (exp !== got) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic cfg(input logic sup, input logic [1:0] o, input logic [1:0] exp);
        @(posedge clk_i) {cfg_we_i, cfg_super_i, cfg_org_i} <= {1'b1, sup, o};
        @(posedge clk_i) cfg_we_i <= 1'b0;
        @(posedge clk_i) #1 chk("org", exp, org);
    endtask : cfg
    task automatic access(input logic we, input logic ifc, input logic [31:0] a, input logic [31:0] w);
        int n;
        m = 1'b0;
        @(posedge clk_i) core_i <= {1'b1, we, ifc, a, w};
        for (n = 0; n < 60; n++) begin
            @(posedge clk_i) #1;
            if (miss === 1'b1) m = 1'b1;
            if (ack === 1'b1) break;
        end
        if (n == 60) begin
            failures++;
            stop_test();
        end
        h = hit;
        d = rdata;
        @(posedge clk_i) core_i.req <= 1'b0;
    endtask : access
    task automatic rd(input logic ifc, input logic [31:0] a, input logic eh, input logic [31:0] ed);
        access(1'b0, ifc, a, 32'h0);
        chk("hit", eh, h);
        chk("miss", !eh, m);
        chk("rdata", ed, d);
    endtask : rd
    function automatic logic [31:0] f(input logic [31:0] a);
        return a ^ 32'h5a5a_0000;
    endfunction : f
    task automatic s_org();
        cfg(1'b0, 2'h2, 2'h0);
        cfg(1'b1, 2'h2, 2'h2);
        cfg(1'b1, 2'h3, 2'h2);
        cfg(1'b1, 2'h1, 2'h1);
        cfg(1'b1, 2'h0, 2'h0);
    endtask : s_org
    task automatic s_icache();
        rd(1'b1, 32'h40, 1'b0, f(32'h40));
        rd(1'b1, 32'h40, 1'b1, f(32'h40));
        rd(1'b1, 32'h4c, 1'b1, f(32'h4c));
        rd(1'b1, 32'h440, 1'b0, f(32'h440));
        rd(1'b1, 32'h40, 1'b1, f(32'h40));
        rd(1'b1, 32'h840, 1'b0, f(32'h840));
        rd(1'b1, 32'h40, 1'b0, f(32'h40));
        rd(1'b0, 32'h80, 1'b0, f(32'h80));
        rd(1'b0, 32'h80, 1'b0, f(32'h80));
    endtask : s_icache
    task automatic s_dcache();
        logic [7:0] n;
        wt <= 2'h3;
        cfg(1'b1, 2'h1, 2'h1);
        rd(1'b0, 32'h1230, 1'b0, f(32'h1230));
        n = wc;
        access(1'b1, 1'b0, 32'h1234, 32'hc0de_0001);
        chk("wr_cnt", n + 8'h1, wc);
        chk("wr_addr", 32'h1234, wa);
        chk("wr_data", 32'hc0de_0001, wd);
        rd(1'b0, 32'h1234, 1'b1, 32'hc0de_0001);
        wt <= 2'h0;
    endtask : s_dcache
    task automatic s_split();
        cfg(1'b1, 2'h2, 2'h2);
        rd(1'b1, 32'h100, 1'b0, f(32'h100));
        rd(1'b0, 32'h100, 1'b0, f(32'h100));
        rd(1'b1, 32'h104, 1'b1, f(32'h104));
        rd(1'b1, 32'h500, 1'b0, f(32'h500));
        rd(1'b0, 32'h108, 1'b1, f(32'h108));
    endtask : s_split
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        s_org();
        s_icache();
        s_dcache();
        s_split();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
